// ### hw/flash_defines.svh
// constants for the host-side stacked flash command sequencer
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH

// ==================================================
// widths
`define FL_ADDR_W      24
`define FL_DATA_W      16
`define FL_SEL_BIT     23

// ==================================================
// timing at 100 MHz
`define CLK_PERIOD_NS  10
`define T_WP_NS        70
`define T_RD_NS        110
`define SYNC_CYC       2
`define WP_CYC         ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC         (((`T_RD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + `SYNC_CYC)

// ==================================================
// status word fields
`define SR_READY_BIT   7
`define SR_ESUS_BIT    6
`define SR_ERASE_ERR   5
`define SR_PROG_ERR    4
`define SR_VPEN_ERR    3
`define SR_PSUS_BIT    2
`define SR_PROT_ERR    1

`endif

// ### hw/flash_pkg.sv
// types shared by the flash host sequencer files
package flash_pkg;

    typedef enum logic [3:0] {
        OP_PROGRAM  = 4'h0,
        OP_ERASE    = 4'h1,
        OP_PROTECT  = 4'h2,
        OP_OTP      = 4'h3,
        OP_POLL     = 4'h4,
        OP_SUSPEND  = 4'h5,
        OP_RESUME   = 4'h6,
        OP_READ     = 4'h7,
        OP_STATUS   = 4'h8
    } op_t;

    typedef struct packed {
        op_t         op;
        logic [23:0] addr;
        logic [15:0] data;
    } host_req_t;

    typedef struct packed {
        logic        write;
        logic [23:0] addr;
        logic [15:0] data;
    } bus_req_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [23:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe;
    } flash_pins_t;

endpackage

// ### hw/flash_bus_cycle.sv
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`include "flash_defines.svh"
module flash_bus_cycle
    import flash_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // cycle request
    input  wire logic                  start,
    input  wire bus_req_t              req,
    output      logic                  done,
    output      logic [`FL_DATA_W-1:0] rdata,
    // flash pins
    output      flash_pins_t           pins,
    input  wire logic [`FL_DATA_W-1:0] dq_in
);

    typedef enum logic [1:0] {
        B_IDLE   = 2'b00,
        B_SETUP  = 2'b01,
        B_STROBE = 2'b10,
        B_HOLD   = 2'b11
    } bstate_t;

    localparam logic [4:0] WP_LAST = 5'(`WP_CYC - 1);
    localparam logic [4:0] RD_LAST = 5'(`RD_CYC - 1);

    bstate_t               state;
    logic [4:0]            cnt;
    logic [`FL_DATA_W-1:0] dq_meta;
    logic [`FL_DATA_W-1:0] dq_sync;

    // read strobe is stretched by the synchroniser depth so data is settled when taken
    always_ff @(posedge clk) begin
        dq_meta <= dq_in;
        dq_sync <= dq_meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= B_IDLE;
            cnt   <= 5'h00;
            done  <= 1'b0;
            rdata <= '0;
            pins  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
        end else begin
            done <= 1'b0;
            unique case (state)
                B_IDLE: begin
                    if (start) begin
                        pins.addr   <= req.addr;
                        pins.dq_out <= req.data;
                        pins.dq_oe  <= req.write;
                        pins.ce_n   <= 1'b0;
                        state       <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    pins.we_n <= ~req.write;
                    pins.oe_n <= req.write;
                    cnt       <= req.write ? WP_LAST : RD_LAST;
                    state     <= B_STROBE;
                end
                B_STROBE: begin
                    if (cnt == 5'h00) begin
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        if (!req.write) begin
                            rdata <= dq_sync;
                        end
                        state <= B_HOLD;
                    end else begin
                        cnt <= cnt - 5'h01;
                    end
                end
                B_HOLD: begin
                    pins.ce_n  <= 1'b1;
                    pins.dq_oe <= 1'b0;
                    done       <= 1'b1;
                    state      <= B_IDLE;
                end
            endcase
        end
    end

endmodule

// ### hw/flash_host_seq.sv
// host sequencer that issues flash commands to the right internal memory
`timescale 1ns/1ps
`include "flash_defines.svh"
module flash_host_seq
    import flash_pkg::*;
#(
    parameter logic [15:0] CMD_PROGRAM     = 16'h0040,
    parameter logic [15:0] CMD_ERASE       = 16'h0020,
    parameter logic [15:0] CMD_CONFIRM     = 16'h00d0,
    parameter logic [15:0] CMD_PROTECT     = 16'h0060,
    parameter logic [15:0] CMD_PROT_CONF   = 16'h0001,
    parameter logic [15:0] CMD_OTP_PROGRAM = 16'h00c0,
    parameter logic [15:0] CMD_SUSPEND     = 16'h00b0,
    parameter logic [15:0] CMD_RESUME      = 16'h00d0,
    parameter logic [15:0] CMD_READ_STATUS = 16'h0070,
    parameter logic [15:0] CMD_CLR_STATUS  = 16'h0050,
    parameter logic [15:0] CMD_READ_ARRAY  = 16'h00ff
)(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // user requests
    input  wire logic                  req_valid,
    input  wire host_req_t             req,
    output      logic                  req_ready,
    output      logic                  done,
    output      logic                  refused,
    output      logic                  op_error,
    output      logic [`FL_DATA_W-1:0] rd_data,
    output      logic [`FL_DATA_W-1:0] status,
    output      logic [1:0]            mem_busy,
    output      logic [1:0]            mem_suspended,
    // flash pins
    output      flash_pins_t           pins,
    input  wire logic [`FL_DATA_W-1:0] dq_in
);

    typedef enum logic [3:0] {
        S_IDLE   = 4'h0,
        S_W1     = 4'h1,
        S_W2     = 4'h2,
        S_RSCMD  = 4'h3,
        S_RSREAD = 4'h4,
        S_CLR    = 4'h5,
        S_RACMD  = 4'h6,
        S_RDATA  = 4'h7,
        S_FIN    = 4'h8
    } state_t;

    // ==================================================
    // sequence registers
    state_t                state;
    logic                  go;
    op_t                   op;
    logic                  mem;
    logic [`FL_ADDR_W-1:0] cmd_addr;
    logic [`FL_ADDR_W-1:0] data_addr;
    logic [`FL_DATA_W-1:0] w1_val;
    logic [`FL_DATA_W-1:0] w2_val;
    logic                  two_writes;
    logic                  do_status;
    logic                  poll_loop;
    logic                  do_array;
    logic                  do_data;
    logic                  saw_error;

    // per-memory bookkeeping; the device keeps its own mode per memory, so we mirror it
    logic [`FL_ADDR_W-1:0] active_addr [2];

    // ==================================================
    // bus cycle engine
    bus_req_t              bus_req;
    logic                  bus_done;
    logic [`FL_DATA_W-1:0] bus_rdata;

    flash_bus_cycle u_cycle (
        .clk   (clk),
        .rst   (rst),
        .start (go),
        .req   (bus_req),
        .done  (bus_done),
        .rdata (bus_rdata),
        .pins  (pins),
        .dq_in (dq_in)
    );

    // ==================================================
    // decode of the incoming request
    wire       req_mem     = req.addr[`FL_SEL_BIT];
    wire       tgt_busy    = mem_busy[req_mem];
    wire       tgt_susp    = mem_suspended[req_mem];
    wire       is_start    = (req.op == OP_PROGRAM) || (req.op == OP_ERASE) ||
                             (req.op == OP_PROTECT) || (req.op == OP_OTP);
    wire       runs        = tgt_busy && !tgt_susp;
    // a started memory accepts no new start; suspended program is not combined with another
    wire       req_bad     = (is_start && tgt_busy) ||
                             ((req.op == OP_POLL || req.op == OP_SUSPEND) && !runs) ||
                             (req.op == OP_RESUME && !tgt_susp) ||
                             (req.op == OP_READ && runs);
    wire       accept      = (state == S_IDLE) && req_valid && !req_bad;
    wire [`FL_ADDR_W-1:0] tracked = active_addr[req_mem];
    // suspend, resume and polls all reuse the address of the operation they act on
    wire [`FL_ADDR_W-1:0] acc_addr = (is_start || !tgt_busy) ? req.addr : tracked;

    // ==================================================
    // next state and bus word per state
    wire       sr_ready    = bus_rdata[`SR_READY_BIT];
    wire       sr_err      = bus_rdata[`SR_ERASE_ERR] | bus_rdata[`SR_PROG_ERR] |
                             bus_rdata[`SR_VPEN_ERR] | bus_rdata[`SR_PROT_ERR];
    wire state_t after_w   = do_status ? S_RSCMD : (do_array ? S_RACMD : S_FIN);
    wire state_t after_sr  = (poll_loop && !sr_ready) ? S_RSCMD :
                             (sr_ready && sr_err) ? S_CLR :
                             (do_array ? S_RACMD : S_FIN);
    wire state_t after_w1  = two_writes ? S_W2 : after_w;
    wire state_t after_ra  = do_data ? S_RDATA : S_FIN;
    // first step worked out from the request itself, since setup registers load in the same edge
    wire       acc_write   = is_start || req.op == OP_SUSPEND || req.op == OP_RESUME;
    wire       acc_status  = req.op == OP_POLL || req.op == OP_STATUS;
    wire state_t first_st_acc = acc_write ? S_W1 : (acc_status ? S_RSCMD : S_RACMD);

    assign bus_req.write = (state != S_RSREAD) && (state != S_RDATA);
    // status reads always follow the address of the command being watched
    assign bus_req.addr  = (state == S_RDATA) ? data_addr : cmd_addr;
    assign bus_req.data  = (state == S_W1)    ? w1_val :
                           (state == S_W2)    ? w2_val :
                           (state == S_RSCMD) ? CMD_READ_STATUS :
                           (state == S_CLR)   ? CMD_CLR_STATUS :
                           (state == S_RACMD) ? CMD_READ_ARRAY : '0;

    // ==================================================
    // sequence setup taken at accept
    always_ff @(posedge clk) begin
        if (rst) begin
            op         <= OP_PROGRAM;
            mem        <= 1'b0;
            cmd_addr   <= '0;
            data_addr  <= '0;
            w1_val     <= '0;
            w2_val     <= '0;
            two_writes <= 1'b0;
            do_status  <= 1'b0;
            poll_loop  <= 1'b0;
            do_array   <= 1'b0;
            do_data    <= 1'b0;
        end else if (accept) begin
            op         <= req.op;
            mem        <= req_mem;
            // read-array goes to the suspended operation's address, else into the target memory
            cmd_addr   <= (req.op == OP_READ && tgt_susp) ? tracked : acc_addr;
            data_addr  <= req.addr;
            w2_val     <= req.data;
            two_writes <= is_start;
            do_status  <= req.op == OP_POLL || req.op == OP_SUSPEND || req.op == OP_STATUS;
            poll_loop  <= req.op == OP_POLL || req.op == OP_SUSPEND;
            do_array   <= req.op == OP_POLL || req.op == OP_SUSPEND || req.op == OP_READ;
            do_data    <= req.op == OP_READ;
            unique case (req.op)
                OP_PROGRAM: w1_val <= CMD_PROGRAM;
                OP_ERASE:   w1_val <= CMD_ERASE;
                OP_PROTECT: w1_val <= CMD_PROTECT;
                OP_OTP:     w1_val <= CMD_OTP_PROGRAM;
                OP_SUSPEND: w1_val <= CMD_SUSPEND;
                OP_RESUME:  w1_val <= CMD_RESUME;
                default:    w1_val <= CMD_READ_STATUS;
            endcase
            if (req.op == OP_ERASE) begin
                w2_val <= CMD_CONFIRM;
            end else if (req.op == OP_PROTECT) begin
                w2_val <= CMD_PROT_CONF;
            end
        end
    end

    // ==================================================
    // state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= S_IDLE;
            go    <= 1'b0;
        end else begin
            go <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (accept) begin
                        state <= first_st_acc;
                        go    <= 1'b1;
                    end
                end
                S_FIN: begin
                    state <= S_IDLE;
                end
                S_W1:     if (bus_done) begin state <= after_w1; go <= after_w1 != S_FIN; end
                S_W2:     if (bus_done) begin state <= after_w;  go <= after_w  != S_FIN; end
                S_RSCMD:  if (bus_done) begin state <= S_RSREAD; go <= 1'b1; end
                S_RSREAD: if (bus_done) begin state <= after_sr; go <= after_sr != S_FIN; end
                S_CLR:    if (bus_done) begin
                    state <= do_array ? S_RACMD : S_FIN;
                    go    <= do_array;
                end
                S_RACMD:  if (bus_done) begin state <= after_ra; go <= after_ra != S_FIN; end
                S_RDATA:  if (bus_done) begin state <= S_FIN; end
                default:  state <= S_IDLE;
            endcase
        end
    end

    // ==================================================
    // results and per-memory bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            req_ready      <= 1'b0;
            done           <= 1'b0;
            refused        <= 1'b0;
            op_error       <= 1'b0;
            saw_error      <= 1'b0;
            rd_data        <= '0;
            status         <= '0;
            mem_busy       <= 2'b00;
            mem_suspended  <= 2'b00;
            active_addr[0] <= '0;
            active_addr[1] <= '0;
        end else begin
            req_ready <= (state == S_IDLE) && !accept;
            done      <= 1'b0;
            refused   <= (state == S_IDLE) && req_valid && req_bad;
            if (accept) begin
                saw_error <= 1'b0;
                if (is_start) begin
                    active_addr[req_mem] <= req.addr;
                end
            end
            if (state == S_RSREAD && bus_done) begin
                status <= bus_rdata;
                if (sr_ready && sr_err) begin
                    saw_error <= 1'b1;
                end
            end
            if (state == S_RDATA && bus_done) begin
                rd_data <= bus_rdata;
            end
            if (state == S_FIN) begin
                done     <= 1'b1;
                op_error <= saw_error;
                unique case (op)
                    OP_PROGRAM, OP_ERASE, OP_PROTECT, OP_OTP: mem_busy[mem] <= 1'b1;
                    OP_POLL:    mem_busy[mem] <= 1'b0;
                    OP_SUSPEND: begin
                        // a suspend that lands after completion leaves nothing suspended
                        mem_suspended[mem] <= status[`SR_ESUS_BIT] | status[`SR_PSUS_BIT];
                        mem_busy[mem]      <= status[`SR_ESUS_BIT] | status[`SR_PSUS_BIT];
                    end
                    OP_RESUME:  mem_suspended[mem] <= 1'b0;
                    default:    mem_busy[mem] <= mem_busy[mem];
                endcase
            end
        end
    end

endmodule

// ### verif/flash_host_seq_assertions.sv
// protocol checks on the flash host sequencer ports
`timescale 1ns/1ps
module flash_host_seq_assertions
    import flash_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // request handshake
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        done,
    input wire logic        refused,
    // flash pins
    input wire flash_pins_t pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ====
    // helper: remembers that the last write was a suspend
    logic        susp_seen;
    logic [23:0] susp_addr;
    always_ff @(posedge clk) begin
        if (rst) begin
            susp_seen <= 1'b0;
            susp_addr <= 24'h000000;
        end else if ($fell(pins.we_n)) begin
            susp_seen <= pins.dq_out == 16'h00b0;
            susp_addr <= pins.addr;
        end
    end

    // ====
    // properties
    a_susp_status: assert property ($fell(pins.we_n) && susp_seen |-> pins.addr == susp_addr)
        else $error("status command after suspend went elsewhere");
    a_done_refused: assert property (!(done && refused))
        else $error("done and refused together");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_ready_back: assert property (done |-> ##[0:1] req_ready)
        else $error("ready not back after done");
    a_bus_busy: assert property (!pins.ce_n |-> !req_ready)
        else $error("bus cycle while idle");
    a_rw_excl: assert property (!(!pins.we_n && !pins.oe_n))
        else $error("read and write strobes together");
    a_write_drive: assert property (!pins.we_n |-> pins.dq_oe && !pins.ce_n)
        else $error("write strobe without driven data");
    a_read_release: assert property (!pins.oe_n |-> !pins.dq_oe && !pins.ce_n)
        else $error("host drives data during read");
    a_we_width: assert property ($fell(pins.we_n) |-> !pins.we_n [*7] ##1 pins.we_n)
        else $error("write strobe width wrong");
    a_oe_width: assert property ($fell(pins.oe_n) |-> ##12 !pins.oe_n ##1 pins.oe_n)
        else $error("read strobe width wrong");
    a_addr_hold: assert property (!pins.we_n && $past(!pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_out))
        else $error("address or data moved under write strobe");
endmodule

// ### verif/flash_dev_model.sv
// behavioural stacked flash with two internal memories, checks command addresses
`timescale 1ns/1ps
module flash_dev_model
    import flash_pkg::*;
#(
    parameter int BUSY_READS = 3
)(
    // flash pins
    input  wire flash_pins_t pins,
    output wire logic [15:0] dq_in,
    // fault control and result
    input  wire logic        err_inj,
    output int               violations
);
    logic [23:0] op_addr [2];
    int          busy    [2] = '{0, 0};
    logic [1:0]  pend    [2] = '{2'h0, 2'h0};
    logic        susp    [2] = '{1'b0, 1'b0};
    logic        smode   [2] = '{1'b0, 1'b0};
    logic        err     [2] = '{1'b0, 1'b0};
    logic        ers     [2] = '{1'b0, 1'b0};
    logic [15:0] last = 16'h0000;
    wire logic        m   = pins.addr[23];
    wire logic [7:0]  sts = {busy[m] == 0 || susp[m], susp[m] && ers[m], 1'b0, err[m], 1'b0, susp[m] && !ers[m], 2'h0};
    wire logic [15:0] rv  = smode[m] ? {8'h00, sts} : pins.addr[15:0];
    // a released bus shows the inverse of the last word so a stale sample cannot pass
    assign dq_in = (!pins.ce_n && !pins.oe_n) ? rv : ~last;
    initial violations = 0;

    // ====
    // busy counts down on status reads, so slow completion needs several polls
    always @(posedge pins.oe_n) begin
        last <= rv;
        if (smode[m] && !susp[m] && busy[m] > 0) begin
            busy[m] <= busy[m] - 1;
            if (busy[m] == 1 && err_inj) err[m] <= 1'b1;
        end
    end

    // ====
    // command decode per selected memory
    always @(posedge pins.we_n) begin
        if (pend[m] != 2'h0) begin
            ers[m]  <= pend[m] == 2'h2;
            pend[m] <= 2'h0;
            busy[m] <= BUSY_READS;
        end else begin
            smode[m] <= 1'b1;
            case (pins.dq_out)
                16'h0040, 16'h0020, 16'h0060, 16'h00c0: begin
                    if (err[m]) violations <= violations + 1;
                    op_addr[m] <= pins.addr;
                    pend[m]    <= pins.dq_out == 16'h0020 ? 2'h2 : 2'h1;
                end
                16'h00b0: begin
                    if (pins.addr !== op_addr[m] || busy[m] == 0) violations <= violations + 1;
                    susp[m] <= 1'b1;
                end
                16'h00d0: begin
                    if (pins.addr !== op_addr[m] || !susp[m]) violations <= violations + 1;
                    susp[m] <= 1'b0;
                end
                16'h0070: if ((busy[m] != 0 || susp[m]) && pins.addr !== op_addr[m]) violations <= violations + 1;
                16'h0050: err[m] <= 1'b0;
                16'h00ff: begin
                    if (susp[m] && pins.addr !== op_addr[m]) violations <= violations + 1;
                    smode[m] <= 1'b0;
                end
                default: ;
            endcase
        end
    end
endmodule

// ### verif/flash_host_seq_tb.sv
// self-checking bench for the flash host sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module flash_host_seq_tb
    import flash_pkg::*;
;
    typedef struct packed {
        op_t         op;
        logic [23:0] addr;
        logic        rf;
        logic [1:0]  busy;
        logic [1:0]  susp;
        logic [15:0] rd;
    } row_t;
    logic        clk, rst, req_valid, req_ready, done, refused, op_error, err_inj, rf;
    host_req_t   req;
    logic [15:0] rd_data, status, dq_in;
    logic [1:0]  mem_busy, mem_suspended;
    flash_pins_t pins;
    int          viol, n_errors = 0, checks_done = 0, cyc = 0;
    row_t rows [20] = '{
        '{OP_PROGRAM, 24'h000010, 1'b0, 2'h1, 2'h0, 16'h0}, '{OP_SUSPEND, 24'h000010, 1'b0, 2'h1, 2'h1, 16'h0},
        '{OP_READ, 24'h800020, 1'b0, 2'h1, 2'h1, 16'h0020}, '{OP_READ, 24'h000030, 1'b0, 2'h1, 2'h1, 16'h0030},
        '{OP_RESUME, 24'h000010, 1'b0, 2'h1, 2'h0, 16'h0}, '{OP_READ, 24'h000050, 1'b1, 2'h1, 2'h0, 16'h0},
        '{OP_POLL, 24'h000010, 1'b0, 2'h0, 2'h0, 16'h0}, '{OP_POLL, 24'h000010, 1'b1, 2'h0, 2'h0, 16'h0},
        '{OP_RESUME, 24'h000010, 1'b1, 2'h0, 2'h0, 16'h0}, '{OP_ERASE, 24'h800100, 1'b0, 2'h2, 2'h0, 16'h0},
        '{OP_SUSPEND, 24'h800100, 1'b0, 2'h2, 2'h2, 16'h0}, '{OP_READ, 24'h000044, 1'b0, 2'h2, 2'h2, 16'h0044},
        '{OP_RESUME, 24'h800100, 1'b0, 2'h2, 2'h0, 16'h0}, '{OP_POLL, 24'h800100, 1'b0, 2'h0, 2'h0, 16'h0},
        '{OP_PROTECT, 24'h000200, 1'b0, 2'h1, 2'h0, 16'h0}, '{OP_POLL, 24'h000200, 1'b0, 2'h0, 2'h0, 16'h0},
        '{OP_OTP, 24'h800300, 1'b0, 2'h2, 2'h0, 16'h0}, '{OP_POLL, 24'h800300, 1'b0, 2'h0, 2'h0, 16'h0},
        '{OP_STATUS, 24'h800000, 1'b0, 2'h0, 2'h0, 16'h0080}, '{OP_READ, 24'h800044, 1'b0, 2'h0, 2'h0, 16'h0044}};

    flash_host_seq dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .done(done), .refused(refused), .op_error(op_error), .rd_data(rd_data), .status(status),
        .mem_busy(mem_busy), .mem_suspended(mem_suspended), .pins(pins), .dq_in(dq_in));
    flash_dev_model dev_u (.pins(pins), .dq_in(dq_in), .err_inj(err_inj), .violations(viol));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task wrap_up();
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ====
    // one request: hold until taken or refused, then wait for done under a bound
    task run(input op_t op, input logic [23:0] a, output logic r);
        int k;
        k = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= '{op: op, addr: a, data: 16'h1234};
        do begin @(negedge clk); k++; end while (req_ready !== 1'b0 && refused !== 1'b1 && k < 3000);
        r = refused;
        @(posedge clk);
        req_valid <= 1'b0;
        while (!r && done !== 1'b1 && k < 3000) begin @(negedge clk); k++; end
        if (k >= 3000) begin n_errors++; wrap_up(); end
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin n_errors++; wrap_up(); end
    end

    initial begin
        rst = 1'b1; req_valid = 1'b0; req = '0; err_inj = 1'b0;
        @(negedge clk);
        `CHK({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, done, refused}, 6'h38)
        @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
        `CHK(req_ready, 1'b1)
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].addr, rf);
            `CHK(rf, rows[i].rf)
            `CHK(mem_suspended, rows[i].susp)
            if (rows[i].susp == 2'h0) `CHK(mem_busy, rows[i].busy)
            if (rows[i].op == OP_READ && !rows[i].rf) `CHK(rd_data, rows[i].rd)
            if (rows[i].op == OP_STATUS) `CHK(status, rows[i].rd)
        end
        // failing program: the host must clear the error before the next program is accepted cleanly
        err_inj <= 1'b1;
        run(OP_PROGRAM, 24'h000060, rf);
        run(OP_POLL, 24'h000060, rf);
        `CHK(op_error, 1'b1)
        err_inj <= 1'b0;
        run(OP_PROGRAM, 24'h000070, rf);
        run(OP_POLL, 24'h000070, rf);
        `CHK(op_error, 1'b0)
        // reset in mid-run must drop the per-memory bookkeeping and restore idle pins
        run(OP_PROGRAM, 24'h800080, rf);
        `CHK(mem_busy, 2'h2)
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK({mem_busy, mem_suspended, op_error, req_ready}, 6'h01)
        `CHK({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 4'he)
        `CHK(viol, 0)
        wrap_up();
    end
endmodule

bind flash_host_seq flash_host_seq_assertions chk_u (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .done(done), .refused(refused), .pins(pins));
